// ==== common/lcdo_pkg.sv ====
// Constants, register map and encodings of the limit check digital output block.
//
// Behaviour
// - Eight independent pass or fail output ports.
// - Each term selects value, port, status or none.
// - Each term holds lower and upper limit.
// - Inversion off: inside range gives pass.
// - Values equal to a limit count inside.
// - Inversion off: status without error gives pass.
// - Inversion on: inside range gives fail.
// - Inversion on: status without error gives fail.
// - Up to eight terms chained by AND/OR/XOR.
// - Pass series needs N consecutive passes.
// - Fail series needs N consecutive fails.
// - Per port threshold N and counted criterion.
// - Pin level follows logic value by default.
// - Global level inversion flips all pins.
package lcdo_pkg;

	// ==========================================================
	// Sizes.
	localparam int PORTS     = 8;
	localparam int TERMS     = 8;
	localparam int VALUES    = 32;
	localparam int VAL_W     = 16;
	localparam int ADDR_W    = 10;
	localparam int DATA_W    = 32;
	localparam int SRC_W     = 6;
	localparam int THR_W     = 8;
	localparam int EVENTS    = 9;

	// ==========================================================
	// Source codes of a term.
	localparam logic [SRC_W-1:0] SRC_NONE      = 6'h00;
	localparam logic [SRC_W-1:0] SRC_VAL_FIRST = 6'h01;
	localparam logic [SRC_W-1:0] SRC_VAL_LAST  = 6'h20;
	localparam logic [SRC_W-1:0] SRC_PORT_FIRST = 6'h21;
	localparam logic [SRC_W-1:0] SRC_PORT_LAST = 6'h28;
	localparam logic [SRC_W-1:0] SRC_STATUS    = 6'h29;

	// ==========================================================
	// Link operations to the next term.
	typedef enum logic [1:0] {
		LINK_NONE = 2'h0,
		LINK_AND  = 2'h1,
		LINK_OR   = 2'h2,
		LINK_XOR  = 2'h3
	} lcdo_link_t;

	// ==========================================================
	// Register word addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 10'h000;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 10'h001;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 10'h002;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 10'h003;
	localparam logic [ADDR_W-1:0] ADDR_RESULT   = 10'h004;
	localparam logic [ADDR_W-1:0] ADDR_SER_BASE = 10'h008;
	localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 10'h010;
	localparam logic [ADDR_W-1:0] ADDR_TERM_BASE = 10'h100;
	localparam int TERM_STRIDE = 4;
	localparam int PORT_STRIDE = 32;
	localparam logic [1:0] TERM_CFG = 2'h0;
	localparam logic [1:0] TERM_MIN = 2'h1;
	localparam logic [1:0] TERM_MAX = 2'h2;

	// ==========================================================
	// Field positions.
	localparam int CTRL_LVL_INV  = 0;
	localparam int CFG_SRC_LSB   = 0;
	localparam int CFG_INV       = 6;
	localparam int CFG_OP_LSB    = 8;
	localparam int SER_THR_LSB   = 0;
	localparam int SER_CRIT      = 8;
	localparam int SER_EN        = 9;
	localparam int RES_PIN_LSB   = 8;
	localparam int EV_ERR        = 8;

	// ==========================================================
	// Reset values.
	localparam logic [THR_W-1:0] THR_RST  = 8'h01;
	localparam logic [VAL_W-1:0] LIM_RST  = 16'h0000;

endpackage : lcdo_pkg

// ==== verilog/lcdo_term.sv ====
// One evaluation term: source selection, inclusive limit check and inversion.
`timescale 1ns/1ns
module lcdo_term (
	// Term configuration
	input  wire logic [lcdo_pkg::SRC_W-1:0]                   src_i,
	input  wire logic                                          inv_i,
	input  wire logic signed [lcdo_pkg::VAL_W-1:0]             lo_i,
	input  wire logic signed [lcdo_pkg::VAL_W-1:0]             hi_i,
	// Signal pool
	input  wire logic [lcdo_pkg::VALUES-1:0][lcdo_pkg::VAL_W-1:0] values_i,
	input  wire logic [lcdo_pkg::PORTS-1:0]                    ports_i,
	input  wire logic                                          status_ok_i,
	// Result
	output logic                                               result_o,
	output logic                                               active_o
);

	wire logic                      is_val;
	wire logic                      is_port;
	wire logic                      is_stat;
	wire logic [4:0]                val_idx;
	wire logic [2:0]                port_idx;
	wire logic signed [lcdo_pkg::VAL_W-1:0] val;
	wire logic                      in_range;
	wire logic                      raw;

	assign is_val   = (src_i >= lcdo_pkg::SRC_VAL_FIRST) && (src_i <= lcdo_pkg::SRC_VAL_LAST);
	assign is_port  = (src_i >= lcdo_pkg::SRC_PORT_FIRST) && (src_i <= lcdo_pkg::SRC_PORT_LAST);
	assign is_stat  = (src_i == lcdo_pkg::SRC_STATUS);
	assign val_idx  = 5'(src_i - lcdo_pkg::SRC_VAL_FIRST);
	assign port_idx = 3'(src_i - lcdo_pkg::SRC_PORT_FIRST);
	assign val      = values_i[val_idx];
	assign in_range = (val >= lo_i) && (val <= hi_i);
	assign raw      = is_val ? in_range : (is_port ? ports_i[port_idx] : status_ok_i);
	assign result_o = raw ^ inv_i;
	assign active_o = is_val | is_port | is_stat;

endmodule : lcdo_term

// ==== verilog/lcdo_top.sv ====
// Limit check digital outputs: term evaluation, link chain, series counters and registers.
`timescale 1ns/1ns
module lcdo_top (
	// Clock and reset
	input  wire logic                                          clock_i,
	input  wire logic                                          rst_n_i,
	// Measurement input
	input  wire logic                                          meas_valid_i,
	input  wire logic                                          status_ok_i,
	input  wire logic [lcdo_pkg::VALUES-1:0][lcdo_pkg::VAL_W-1:0] values_i,
	// Register port
	input  wire logic [lcdo_pkg::ADDR_W-1:0]                   reg_addr_i,
	input  wire logic [lcdo_pkg::DATA_W-1:0]                   reg_wdata_i,
	input  wire logic                                          reg_wr_i,
	input  wire logic                                          reg_rd_i,
	output logic [lcdo_pkg::DATA_W-1:0]                        reg_rdata_o,
	// Outputs
	output logic [lcdo_pkg::PORTS-1:0]                         dout_o,
	output logic                                               irq_o
);

	localparam int NT = lcdo_pkg::PORTS * lcdo_pkg::TERMS;
	localparam int ADDR_W_HI = lcdo_pkg::ADDR_W - 1;

	// ==========================================================
	// Storage.
	logic [lcdo_pkg::SRC_W-1:0]         src_q [NT];
	logic                               inv_q [NT];
	logic [1:0]                         op_q  [NT];
	logic [lcdo_pkg::VAL_W-1:0]         lo_q  [NT];
	logic [lcdo_pkg::VAL_W-1:0]         hi_q  [NT];
	logic [lcdo_pkg::THR_W-1:0]         thr_q [lcdo_pkg::PORTS];
	logic [lcdo_pkg::PORTS-1:0]         crit_q;
	logic [lcdo_pkg::PORTS-1:0]         ser_en_q;
	logic [lcdo_pkg::THR_W-1:0]         cnt_q [lcdo_pkg::PORTS];
	logic [lcdo_pkg::PORTS-1:0]         logic_q;
	logic                               lvl_inv_q;
	logic [lcdo_pkg::EVENTS-1:0]        ev_stat_q;
	logic [lcdo_pkg::EVENTS-1:0]        ev_en_q;
	logic [lcdo_pkg::DATA_W-1:0]        rdata_q;
	logic [lcdo_pkg::PORTS-1:0]         dout_q;
	logic                               irq_q;

	// ==========================================================
	// Address decode.
	wire logic                          term_hit;
	wire logic [5:0]                    term_idx;
	wire logic [1:0]                    term_reg;
	wire logic                          ser_hit;
	wire logic                          cnt_hit;
	wire logic [2:0]                    port_sel;
	wire logic                          wr_ctrl;
	wire logic                          wr_clr;
	wire logic                          wr_en;
	wire logic                          wr_ser;
	wire logic                          wr_term;
	wire logic [lcdo_pkg::EVENTS-1:0]   clr_bits;

	assign term_hit = (reg_addr_i >= lcdo_pkg::ADDR_TERM_BASE)
		&& (reg_addr_i[1:0] != 2'h3);
	assign term_idx = reg_addr_i[7:2];
	assign term_reg = reg_addr_i[1:0];
	assign ser_hit  = (reg_addr_i[ADDR_W_HI:3] == lcdo_pkg::ADDR_SER_BASE[ADDR_W_HI:3]);
	assign cnt_hit  = (reg_addr_i[ADDR_W_HI:3] == lcdo_pkg::ADDR_CNT_BASE[ADDR_W_HI:3]);
	assign port_sel = reg_addr_i[2:0];
	assign wr_ctrl  = reg_wr_i && (reg_addr_i == lcdo_pkg::ADDR_CTRL);
	assign wr_clr   = reg_wr_i && (reg_addr_i == lcdo_pkg::ADDR_IRQ_CLR);
	assign wr_en    = reg_wr_i && (reg_addr_i == lcdo_pkg::ADDR_IRQ_EN);
	assign wr_ser   = reg_wr_i && ser_hit;
	assign wr_term  = reg_wr_i && term_hit && (reg_addr_i < 10'h200);
	assign clr_bits = wr_clr ? reg_wdata_i[lcdo_pkg::EVENTS-1:0] : '0;

	// ==========================================================
	// Term evaluation.
	wire logic [NT-1:0]                 term_res;
	wire logic [NT-1:0]                 term_act;

	generate
		for (genvar t = 0; t < NT; t++)
		begin : g_term
			lcdo_term u_term (
				.src_i       (src_q[t]),
				.inv_i       (inv_q[t]),
				.lo_i        (lo_q[t]),
				.hi_i        (hi_q[t]),
				.values_i    (values_i),
				.ports_i     (logic_q),
				.status_ok_i (status_ok_i),
				.result_o    (term_res[t]),
				.active_o    (term_act[t])
			);
		end
	endgenerate

	// ==========================================================
	// Link chain per port.
	logic [lcdo_pkg::PORTS-1:0]         eval;

	always_comb
	begin
		logic acc;
		logic go;
		int   b;
		acc = 1'b0;
		go  = 1'b0;
		b   = 0;
		for (int p = 0; p < lcdo_pkg::PORTS; p++)
		begin
			b   = p * lcdo_pkg::TERMS;
			acc = term_act[b] & term_res[b];
			go  = term_act[b];
			for (int k = 1; k < lcdo_pkg::TERMS; k++)
			begin
				if (go && term_act[b + k] && (op_q[b + k - 1] != 2'(lcdo_pkg::LINK_NONE)))
				begin
					case (op_q[b + k - 1])
						2'(lcdo_pkg::LINK_AND): acc = acc & term_res[b + k];
						2'(lcdo_pkg::LINK_OR):  acc = acc | term_res[b + k];
						default:                acc = acc ^ term_res[b + k];
					endcase
				end
				else
				begin
					go = 1'b0;
				end
			end
			eval[p] = acc;
		end
	end

	// ==========================================================
	// Series counters.
	logic [lcdo_pkg::PORTS-1:0]         hit;
	logic [lcdo_pkg::PORTS-1:0]         next_logic;
	logic [lcdo_pkg::THR_W-1:0]         cnt_d [lcdo_pkg::PORTS];

	always_comb
	begin
		for (int p = 0; p < lcdo_pkg::PORTS; p++)
		begin
			hit[p] = (eval[p] == crit_q[p]);
			if (!hit[p])
			begin
				cnt_d[p] = '0;
			end
			else if (cnt_q[p] < thr_q[p])
			begin
				cnt_d[p] = cnt_q[p] + 8'h01;
			end
			else
			begin
				cnt_d[p] = cnt_q[p];
			end
			if (ser_en_q[p])
			begin
				next_logic[p] = (cnt_d[p] >= thr_q[p]) ? crit_q[p] : ~crit_q[p];
			end
			else
			begin
				next_logic[p] = eval[p];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			logic_q <= '0;
			for (int p = 0; p < lcdo_pkg::PORTS; p++)
			begin
				cnt_q[p] <= '0;
			end
		end
		else if (meas_valid_i)
		begin
			logic_q <= next_logic;
			for (int p = 0; p < lcdo_pkg::PORTS; p++)
			begin
				cnt_q[p] <= cnt_d[p];
			end
		end
	end

	// ==========================================================
	// Pin level.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dout_q <= '0;
		end
		else
		begin
			dout_q <= logic_q ^ {lcdo_pkg::PORTS{lvl_inv_q}};
		end
	end

	// ==========================================================
	// Configuration registers.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lvl_inv_q <= 1'b0;
			crit_q    <= '0;
			ser_en_q  <= '0;
			for (int p = 0; p < lcdo_pkg::PORTS; p++)
			begin
				thr_q[p] <= lcdo_pkg::THR_RST;
			end
		end
		else
		begin
			if (wr_ctrl)
			begin
				lvl_inv_q <= reg_wdata_i[lcdo_pkg::CTRL_LVL_INV];
			end
			if (wr_ser)
			begin
				thr_q[port_sel]    <= reg_wdata_i[lcdo_pkg::SER_THR_LSB +: lcdo_pkg::THR_W];
				crit_q[port_sel]   <= reg_wdata_i[lcdo_pkg::SER_CRIT];
				ser_en_q[port_sel] <= reg_wdata_i[lcdo_pkg::SER_EN];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int t = 0; t < NT; t++)
			begin
				src_q[t] <= lcdo_pkg::SRC_NONE;
				inv_q[t] <= 1'b0;
				op_q[t]  <= 2'(lcdo_pkg::LINK_NONE);
				lo_q[t]  <= lcdo_pkg::LIM_RST;
				hi_q[t]  <= lcdo_pkg::LIM_RST;
			end
		end
		else if (wr_term)
		begin
			if (term_reg == lcdo_pkg::TERM_CFG)
			begin
				src_q[term_idx] <= reg_wdata_i[lcdo_pkg::CFG_SRC_LSB +: lcdo_pkg::SRC_W];
				inv_q[term_idx] <= reg_wdata_i[lcdo_pkg::CFG_INV];
				op_q[term_idx]  <= reg_wdata_i[lcdo_pkg::CFG_OP_LSB +: 2];
			end
			else if (term_reg == lcdo_pkg::TERM_MIN)
			begin
				lo_q[term_idx] <= reg_wdata_i[lcdo_pkg::VAL_W-1:0];
			end
			else
			begin
				hi_q[term_idx] <= reg_wdata_i[lcdo_pkg::VAL_W-1:0];
			end
		end
	end

	// ==========================================================
	// Interrupts.
	wire logic [lcdo_pkg::EVENTS-1:0]   ev_set;

	assign ev_set = meas_valid_i ? {~status_ok_i, next_logic ^ logic_q} : '0;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ev_stat_q <= '0;
			ev_en_q   <= '0;
			irq_q     <= 1'b0;
		end
		else
		begin
			// A new event wins over a clear in the same cycle.
			ev_stat_q <= (ev_stat_q & ~clr_bits) | ev_set;
			if (wr_en)
			begin
				ev_en_q <= reg_wdata_i[lcdo_pkg::EVENTS-1:0];
			end
			irq_q <= |(ev_stat_q & ev_en_q);
		end
	end

	// ==========================================================
	// Read path.
	logic [lcdo_pkg::DATA_W-1:0]        rd_mux;

	always_comb
	begin
		rd_mux = '0;
		if (reg_addr_i == lcdo_pkg::ADDR_CTRL)
		begin
			rd_mux[lcdo_pkg::CTRL_LVL_INV] = lvl_inv_q;
		end
		else if (reg_addr_i == lcdo_pkg::ADDR_IRQ_STAT)
		begin
			rd_mux[lcdo_pkg::EVENTS-1:0] = ev_stat_q;
		end
		else if (reg_addr_i == lcdo_pkg::ADDR_IRQ_EN)
		begin
			rd_mux[lcdo_pkg::EVENTS-1:0] = ev_en_q;
		end
		else if (reg_addr_i == lcdo_pkg::ADDR_RESULT)
		begin
			rd_mux[lcdo_pkg::PORTS-1:0] = logic_q;
			rd_mux[lcdo_pkg::RES_PIN_LSB +: lcdo_pkg::PORTS] = dout_q;
		end
		else if (ser_hit)
		begin
			rd_mux[lcdo_pkg::SER_THR_LSB +: lcdo_pkg::THR_W] = thr_q[port_sel];
			rd_mux[lcdo_pkg::SER_CRIT] = crit_q[port_sel];
			rd_mux[lcdo_pkg::SER_EN]   = ser_en_q[port_sel];
		end
		else if (cnt_hit)
		begin
			rd_mux[lcdo_pkg::THR_W-1:0] = cnt_q[port_sel];
		end
		else if (term_hit && (reg_addr_i < 10'h200))
		begin
			if (term_reg == lcdo_pkg::TERM_CFG)
			begin
				rd_mux[lcdo_pkg::CFG_SRC_LSB +: lcdo_pkg::SRC_W] = src_q[term_idx];
				rd_mux[lcdo_pkg::CFG_INV] = inv_q[term_idx];
				rd_mux[lcdo_pkg::CFG_OP_LSB +: 2] = op_q[term_idx];
			end
			else if (term_reg == lcdo_pkg::TERM_MIN)
			begin
				rd_mux[lcdo_pkg::VAL_W-1:0] = lo_q[term_idx];
			end
			else
			begin
				rd_mux[lcdo_pkg::VAL_W-1:0] = hi_q[term_idx];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_q <= '0;
		end
		else
		begin
			rdata_q <= reg_rd_i ? rd_mux : '0;
		end
	end

	// ==========================================================
	// Outputs.
	assign reg_rdata_o = rdata_q;
	assign dout_o      = dout_q;
	assign irq_o       = irq_q;

endmodule : lcdo_top

// ==== dv/lcdo_chk.sv ====
// Port assertions of the limit check digital output block.
`timescale 1ns/1ns
module lcdo_chk (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	// Inputs
	input wire logic        meas_valid_i,
	input wire logic [9:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	// Outputs
	input wire logic [31:0] reg_rdata_o,
	input wire logic [7:0]  dout_o,
	input wire logic        irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// Decodes and the level invert shadow.
	logic inv_q;
	wire w_ctrl = reg_wr_i && reg_addr_i == lcdo_pkg::ADDR_CTRL;
	wire w_en   = reg_wr_i && reg_addr_i == lcdo_pkg::ADDR_IRQ_EN;
	wire w_clr  = reg_wr_i && reg_addr_i == lcdo_pkg::ADDR_IRQ_CLR && reg_wdata_i[8:0] == 9'h1FF;
	wire r_res  = reg_rd_i && reg_addr_i == lcdo_pkg::ADDR_RESULT;
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			inv_q <= 1'b0;
		else if (w_ctrl)
			inv_q <= reg_wdata_i[0];
	end
	// ==========================================================
	// Properties.
	property p_rd_idle;
		!reg_rd_i |=> reg_rdata_o == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read");
	property p_unmapped;
		reg_rd_i && reg_addr_i == 10'h005 |=> reg_rdata_o == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_pin_cause;
		$changed(dout_o) |-> $past(meas_valid_i, 2) || $past(w_ctrl, 2);
	endproperty
	a_pin_cause: assert property (p_pin_cause)
		else $error("pins changed without measurement or level write");
	property p_pin_out;
		r_res |=> reg_rdata_o[15:8] == $past(dout_o);
	endproperty
	a_pin_out: assert property (p_pin_out)
		else $error("pin levels read differ from pins");
	property p_pin_lvl;
		r_res && !meas_valid_i && !$past(meas_valid_i) && !$past(w_ctrl)
			|=> reg_rdata_o[15:8] == (reg_rdata_o[7:0] ^ {8{inv_q}});
	endproperty
	a_pin_lvl: assert property (p_pin_lvl)
		else $error("pin level not logic value xor level invert");
	property p_irq_en;
		w_en && reg_wdata_i[8:0] == 9'h000 ##1 !w_en |=> !irq_o;
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("interrupt high with all enables off");
	property p_irq_clr;
		!$past(meas_valid_i) && w_clr && !meas_valid_i ##1 !meas_valid_i |=> !irq_o;
	endproperty
	a_irq_clr: assert property (p_irq_clr)
		else $error("interrupt high after full clear");
	property p_rst_zero;
		$rose(rst_n_i) |-> dout_o == 8'h00 && !irq_o;
	endproperty
	a_rst_zero: assert property (p_rst_zero)
		else $error("outputs not low after reset");
	c_meas: cover property (meas_valid_i ##2 $changed(dout_o));
	c_inv: cover property (w_ctrl ##2 $changed(dout_o));
	c_irq: cover property ($rose(irq_o));
endmodule : lcdo_chk

bind lcdo_top lcdo_chk u_chk (
	.clock_i      (clock_i),
	.rst_n_i      (rst_n_i),
	.meas_valid_i (meas_valid_i),
	.reg_addr_i   (reg_addr_i),
	.reg_wdata_i  (reg_wdata_i),
	.reg_wr_i     (reg_wr_i),
	.reg_rd_i     (reg_rd_i),
	.reg_rdata_o  (reg_rdata_o),
	.dout_o       (dout_o),
	.irq_o        (irq_o)
);

// ==== dv/lcdo_pin_reader.sv ====
// Model of the equipment that reads the eight pass or fail pins.
`timescale 1ns/1ns
module lcdo_pin_reader (
	// Pins and level setting
	input  wire logic [7:0] pins_i,
	input  wire logic       lvl_inv_i,
	// Pass per port as the equipment sees it
	output logic [7:0]      pass_o
);
	// ==========================================================
	// Pass reads high unless the level is inverted.
	assign pass_o = pins_i ^ {8{lvl_inv_i}};
endmodule : lcdo_pin_reader

// ==== dv/tb_lcdo_top.sv ====
// Self-checking bench of the limit check digital output block.
`timescale 1ns/1ns
module tb_lcdo_top;
	// ==========================================================
	// Signals.
	localparam logic signed [15:0] LO = 16'hFF9C;
	localparam logic signed [15:0] HI = 16'h0064;
	logic                  clock_i = 1'b0;
	logic                  rst_n_i = 1'b0;
	logic                  meas_valid_i = 1'b0;
	logic                  status_ok_i = 1'b1;
	logic [31:0][15:0]     values_i = '0;
	logic [9:0]            reg_addr_i = 10'h000;
	logic [31:0]           reg_wdata_i = 32'h00000000;
	logic                  reg_wr_i = 1'b0;
	logic                  reg_rd_i = 1'b0;
	logic [31:0]           reg_rdata_o;
	logic [7:0]            dout_o;
	logic [7:0]            pass_seen;
	logic                  irq_o;
	logic [15:0]           seed = 16'h2831;
	logic [7:0]            prev_q = 8'h00;
	logic [7:0]            cnt7 = 8'h00;
	logic                  lvl_inv = 1'b0;
	logic                  crit7 = 1'b0;
	int                    n_fail = 0;
	int                    tests_run = 0;
	always #50 clock_i = ~clock_i;
	lcdo_top dut (
		.clock_i      (clock_i),
		.rst_n_i      (rst_n_i),
		.meas_valid_i (meas_valid_i),
		.status_ok_i  (status_ok_i),
		.values_i     (values_i),
		.reg_addr_i   (reg_addr_i),
		.reg_wdata_i  (reg_wdata_i),
		.reg_wr_i     (reg_wr_i),
		.reg_rd_i     (reg_rd_i),
		.reg_rdata_o  (reg_rdata_o),
		.dout_o       (dout_o),
		.irq_o        (irq_o)
	);
	lcdo_pin_reader u_rdr (.pins_i(dout_o), .lvl_inv_i(lvl_inv), .pass_o(pass_seen));
	// ==========================================================
	// Expectation functions and bus tasks.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [7:0] expect_raw(input logic ok, input logic [7:0] prv);
		logic [7:0] r;
		for (int p = 0; p < 8; p++)
			r[p] = ($signed(values_i[4*p]) >= LO && $signed(values_i[4*p]) <= HI) ^ p[0];
		r[2] = r[2] & ok;
		r[3] = r[3] | ok;
		r[4] = r[4] ^ ~ok;
		r[5] = 1'b0;
		r[6] = r[6] & prv[0];
		return r;
	endfunction : expect_raw
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic reg_write(input logic [9:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [9:0] a, input logic [31:0] e);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		check(reg_rdata_o, e);
	endtask : reg_read
	task automatic measure(input logic ok, input logic [31:0][15:0] v);
		logic [7:0] r;
		@(posedge clock_i);
		values_i <= v;
		status_ok_i <= ok;
		meas_valid_i <= 1'b1;
		@(posedge clock_i);
		meas_valid_i <= 1'b0;
		#1;
		r = expect_raw(ok, prev_q);
		cnt7 = (r[7] == crit7) ? ((cnt7 < 8'h03) ? cnt7 + 8'h01 : 8'h03) : 8'h00;
		r[7] = (cnt7 >= 8'h03) ? crit7 : ~crit7;
		prev_q = r;
		reg_read(lcdo_pkg::ADDR_RESULT, {16'h0000, r ^ {8{lvl_inv}}, r});
		check({24'h000000, pass_seen}, {24'h000000, r});
		reg_read(lcdo_pkg::ADDR_CNT_BASE + 10'h007, {24'h000000, cnt7});
	endtask : measure
	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// ==========================================================
	// Main sequence and watchdog.
	initial
	begin
		#(100 * 20000);
		n_fail++;
		end_sim();
	end
	initial
	begin
		logic [31:0][15:0] v;
		logic [9:0]        a;
		logic [1:0]        op;
		logic [7:0]        old;
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		reg_read(lcdo_pkg::ADDR_CTRL, 32'h00000000);
		reg_read(lcdo_pkg::ADDR_TERM_BASE + 10'h001, 32'h00000000);
		reg_read(10'h005, 32'h00000000);
		for (int p = 0; p < 8; p++)
		begin
			reg_read(lcdo_pkg::ADDR_SER_BASE + 10'(p), 32'h00000001);
			a = lcdo_pkg::ADDR_TERM_BASE + 10'(32 * p);
			op = (p == 2 || p == 6) ? 2'h1 : (p == 3) ? 2'h2 : (p == 4) ? 2'h3 : 2'h0;
			reg_write(a, {22'h000000, op, 1'b0, p[0], (p == 5) ? 6'h00 : 6'(4 * p + 1)});
			reg_read(a, {22'h000000, op, 1'b0, p[0], (p == 5) ? 6'h00 : 6'(4 * p + 1)});
			reg_write(a + 10'h001, {16'h0000, LO});
			reg_write(a + 10'h002, {16'h0000, HI});
			reg_read(a + 10'h002, {16'h0000, HI});
			if (p >= 2 && p <= 4)
				reg_write(a + 10'h004, (p == 4) ? 32'h00000069 : 32'h00000029);
			if (p == 6)
				reg_write(a + 10'h004, 32'h00000021);
		end
		reg_write(lcdo_pkg::ADDR_SER_BASE + 10'h007, 32'h00000203);
		reg_read(lcdo_pkg::ADDR_SER_BASE + 10'h007, 32'h00000203);
		for (int k = 0; k < 2; k++)
		begin
			v = '0;
			v[0] = k ? LO : HI;
			v[4] = k ? HI : LO;
			v[8] = k ? LO - 16'h0001 : HI + 16'h0001;
			v[12] = k ? HI + 16'h0001 : LO - 16'h0001;
			measure(k[0], v);
		end
		for (int n = 0; n < 48; n++)
		begin
			for (int i = 0; i < 32; i++)
			begin
				seed = lfsr(seed);
				v[i] = {{8{seed[7]}}, seed[7:0]};
			end
			if (n == 12)
			begin
				reg_write(lcdo_pkg::ADDR_SER_BASE + 10'h007, 32'h00000303);
				crit7 = 1'b1;
			end
			if (n >= 12 && n < 16)
				v[28] = HI + 16'h0001;
			if (n == 24)
			begin
				reg_write(lcdo_pkg::ADDR_CTRL, 32'h00000001);
				lvl_inv = 1'b1;
				@(posedge clock_i);
				#1;
				check({24'h000000, dout_o}, {24'h000000, ~prev_q});
			end
			measure(seed[9] | seed[10], v);
		end
		reg_write(lcdo_pkg::ADDR_IRQ_EN, 32'h00000100);
		measure(1'b0, v);
		check({31'h00000000, irq_o}, 32'h00000001);
		reg_write(lcdo_pkg::ADDR_IRQ_EN, 32'h00000000);
		@(posedge clock_i);
		#1;
		check({31'h00000000, irq_o}, 32'h00000000);
		reg_write(lcdo_pkg::ADDR_IRQ_EN, 32'h00000100);
		@(posedge clock_i);
		#1;
		check({31'h00000000, irq_o}, 32'h00000001);
		reg_write(lcdo_pkg::ADDR_IRQ_CLR, 32'h000001FF);
		@(posedge clock_i);
		#1;
		check({31'h00000000, irq_o}, 32'h00000000);
		reg_read(lcdo_pkg::ADDR_IRQ_STAT, 32'h00000000);
		reg_read(lcdo_pkg::ADDR_IRQ_CLR, 32'h00000000);
		old = prev_q;
		measure(1'b1, '0);
		reg_read(lcdo_pkg::ADDR_IRQ_STAT, {24'h000000, old ^ prev_q});
		end_sim();
	end
endmodule : tb_lcdo_top
